/* pkg/pcstk_pkg.sv */
`default_nettype none
package pcstk_pkg;
	// =====================================================
	// Sizes and fixed addresses
	localparam int             PC_W       = 21;
	localparam int             SP_W       = 5;
	localparam logic [4:0]     SP_EMPTY   = 5'h00;
	localparam logic [4:0]     SP_TOP     = 5'h1f;
	localparam logic [20:0]    PC_STEP    = 21'h000002;
	localparam logic [20:0]    ONCHIP_END = 21'h003fff;
	localparam logic [20:0]    BOOT_END   = 21'h0007ff;
	// =====================================================
	// Register byte offsets on the bus
	localparam logic [7:0]     ADR_CFG    = 8'h00;
	localparam logic [7:0]     ADR_MEMCTL = 8'h04;
	localparam logic [7:0]     ADR_PCLOW  = 8'h08;
	localparam logic [7:0]     ADR_LATH   = 8'h0c;
	localparam logic [7:0]     ADR_LATU   = 8'h10;
	localparam logic [7:0]     ADR_SPTR   = 8'h14;
	localparam logic [7:0]     ADR_TOP_ENTRY_LOW   = 8'h18;
	localparam logic [7:0]     ADR_TOP_ENTRY_HIGH   = 8'h1c;
	localparam logic [7:0]     ADR_TOP_ENTRY_UPPER   = 8'h20;
	localparam logic [7:0]     ADR_CTRL   = 8'h24;
	// =====================================================
	// Field positions and reset values
	localparam int             CFG_WAIT   = 7;
	localparam int             CFG_BW     = 6;
	localparam logic [7:0]     CFG_MASK   = 8'hc3;
	localparam logic [7:0]     CFG_RESET  = 8'hc3;
	localparam int             MEM_WAIT   = 4;
	localparam logic [7:0]     MEM_MASK   = 8'h30;
	localparam logic [7:0]     MEM_RESET  = 8'h00;
	localparam int             SPR_FULL   = 7;
	localparam int             SPR_UNF    = 6;
	localparam logic [7:0]     CTRL_RESET = 8'h01;
	// =====================================================
	// Types
	typedef enum logic [1:0] {
		MM_EXTENDED = 2'b00,
		MM_BOOT     = 2'b01,
		MM_EXTONLY  = 2'b10,
		MM_ONCHIP   = 2'b11
	} pcstk_mode_t;
	typedef struct packed {
		logic        advance;
		logic        push;
		logic        pop;
		logic        jump;
		logic [20:0] target;
	} pcstk_cmd_t;
	typedef struct packed {
		logic external;
		logic blocked;
	} pcstk_route_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} pcstk_wbreq_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pcstk_wbrsp_t;
endpackage
`default_nettype wire

/* rtl/pcstk_top.sv */
`timescale 1ns/1ps
`default_nettype none
module pcstk_top
	import pcstk_pkg::*;
#(
	parameter logic [20:0] ONCHIP_LAST = pcstk_pkg::ONCHIP_END
) (
	input  wire logic                    clk,          // Core clock
	input  wire logic                    reset,        // Power-on reset
	input  wire logic                    warmReset,    // Other device resets
	input  wire pcstk_pkg::pcstk_cmd_t   cmd,          // Core sequencing request
	input  wire logic [20:0]             tblAddr,      // Table access address
	input  wire pcstk_pkg::pcstk_wbreq_t wbReq,        // Bus request
	output pcstk_pkg::pcstk_wbrsp_t      wbRsp,        // Bus answer
	output logic [20:0]                  fetchAddr_q,  // Fetch address
	output pcstk_pkg::pcstk_route_t      fetchRoute_q, // Fetch target
	output pcstk_pkg::pcstk_route_t      tblRoute_q,   // Table target
	output logic                         busWide_q,    // 16-bit external bus
	output logic [1:0]                   waitCount_q,  // External wait states
	output logic                         stackFault_q  // Stack fault reset
);
	import pcstk_pkg::*;

	// =====================================================
	// State
	logic [7:0]  cfg_q;
	logic [7:0]  memctl_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  latH_q;
	logic [4:0]  latU_q;
	logic [20:0] pc_q;
	logic [20:0] pc_d;
	logic [4:0]  sp_q;
	logic [4:0]  sp_d;
	logic        full_q;
	logic        full_d;
	logic        unf_q;
	logic        unf_d;
	logic        ack_q;
	logic [31:0] dat_q;
	logic        pushWr;
	logic        faultNow;
	logic        setFull;
	logic        setUnf;
	logic [20:0] stk [1:31];

	// =====================================================
	// Bus decode
	// A strobe still held in the ack cycle is not taken a second time
	wire         take     = wbReq.cyc & wbReq.stb & ~ack_q;
	wire         wr       = take & wbReq.we & wbReq.sel[0];
	wire         rd       = take & ~wbReq.we;
	wire [7:0]   wd       = wbReq.dat[7:0];
	wire         hitCfg   = wbReq.adr == ADR_CFG;
	wire         hitMem   = wbReq.adr == ADR_MEMCTL;
	wire         hitPcl   = wbReq.adr == ADR_PCLOW;
	wire         hitLatH  = wbReq.adr == ADR_LATH;
	wire         hitLatU  = wbReq.adr == ADR_LATU;
	wire         hitSp    = wbReq.adr == ADR_SPTR;
	wire         hitTosL  = wbReq.adr == ADR_TOP_ENTRY_LOW;
	wire         hitTosH  = wbReq.adr == ADR_TOP_ENTRY_HIGH;
	wire         hitTosU  = wbReq.adr == ADR_TOP_ENTRY_UPPER;
	wire         hitCtrl  = wbReq.adr == ADR_CTRL;
	wire         busPclWr = wr & hitPcl;
	wire         busPclRd = rd & hitPcl;
	wire         busSpWr  = wr & hitSp;
	wire         tosWr    = wr & (hitTosL | hitTosH | hitTosU) & (sp_q != SP_EMPTY);
	wire         stack_fault_reset_enable   = ctrl_q[0];
	wire [4:0]   spInc    = sp_q + 5'h01;
	wire [20:0]  tos      = (sp_q == SP_EMPTY) ? 21'h000000 : stk[sp_q];
	wire [7:0]   spByte   = {full_q, unf_q, 1'b0, sp_q};
	wire pcstk_mode_t mode = pcstk_mode_t'(cfg_q[1:0]);

	// Read selection; unmapped offsets read zero
	// counter low byte only; counter high and upper bytes go through latches
	wire [7:0] rdByte =
		hitCfg  ? (cfg_q & CFG_MASK) :
		hitMem  ? memctl_q :
		hitPcl  ? pc_q[7:0] :
		hitLatH ? latH_q :
		hitLatU ? {3'h0, latU_q} :
		hitSp   ? spByte :
		hitTosL ? tos[7:0] :
		hitTosH ? tos[15:8] :
		hitTosU ? {3'h0, tos[20:16]} :
		hitCtrl ? ctrl_q : 8'h00;

	assign wbRsp = '{ack: ack_q, dat: dat_q};

	// =====================================================
	// Memory routing by mode
	function automatic pcstk_route_t routeOf(input pcstk_mode_t m, input logic [20:0] a);
		pcstk_route_t r;
		r = '{external: 1'b0, blocked: 1'b0};
		unique case (m)
			// on-chip only, high reads blocked to zero
			MM_ONCHIP:   r.blocked  = a > ONCHIP_LAST;
			MM_EXTENDED: r.external = a > ONCHIP_LAST;
			MM_EXTONLY:  r.external = 1'b1;
			MM_BOOT:     r.external = a > BOOT_END;
		endcase
		return r;
	endfunction

	// =====================================================
	// Counter and stack next state
	// Bus pointer and low byte writes win over the core request, though a stack fault beats a pointer write; a push over top entry writes,
	// so software must keep interrupts off while editing the stack.
	always_comb begin
		pc_d     = pc_q;
		sp_d     = sp_q;
		pushWr   = 1'b0;
		faultNow = 1'b0;
		setFull  = 1'b0;
		setUnf   = 1'b0;
		if (cmd.pop) begin
			if (sp_q == SP_EMPTY) begin
				pc_d     = 21'h000000;
				setUnf   = 1'b1;
				faultNow = stack_fault_reset_enable;
			end else begin
				pc_d = tos;
				sp_d = sp_q - 5'h01;
			end
		end else if (cmd.push) begin
			// push with pre-increment; target loads directly
			pc_d = cmd.target;
			if (sp_q != SP_TOP) begin
				pushWr = 1'b1;
				sp_d   = spInc;
				if (spInc == SP_TOP) begin
					setFull  = 1'b1;
					faultNow = stack_fault_reset_enable;
				end
			end else begin
				setFull = 1'b1;
			end
		end else if (cmd.jump) begin
			pc_d = cmd.target;
		end else if (cmd.advance) begin
			pc_d = pc_q + PC_STEP;
		end
		if (busSpWr)
			sp_d = wd[4:0];
		// low byte write pulls in latches
		if (busPclWr)
			pc_d = {latU_q, latH_q, wd};
		// fault reset zeroes pointer
		// Applied last so a fault beats a pointer write in the same cycle
		if (faultNow)
			sp_d = SP_EMPTY;
		pc_d[0] = 1'b0;
	end

	// sticky flags: hardware set wins over software clear
	assign full_d = setFull | (full_q & ~(busSpWr & ~wd[SPR_FULL]));
	assign unf_d  = setUnf  | (unf_q  & ~(busSpWr & ~wd[SPR_UNF]));

	// =====================================================
	// Counter, pointer and flags
	always_ff @(posedge clk) begin
		if (reset) begin
			pc_q   <= '0;
			sp_q   <= SP_EMPTY;
			full_q <= 1'b0;
			unf_q  <= 1'b0;
		end else begin
			// every reset clears pointer, flags survive warm reset
			pc_q   <= warmReset ? 21'h000000 : pc_d;
			sp_q   <= warmReset ? SP_EMPTY : sp_d;
			full_q <= full_d;
			unf_q  <= unf_d;
		end
	end

	// Stack storage: no reset, position zero has none
	// No reset on the array saves area; pointer zero hides stale entries
	always_ff @(posedge clk) begin
		if (pushWr)
			stk[spInc] <= pc_q + PC_STEP;
		else if (tosWr & hitTosL)
			stk[sp_q][7:0] <= wd;
		else if (tosWr & hitTosH)
			stk[sp_q][15:8] <= wd;
		else if (tosWr & hitTosU)
			stk[sp_q][20:16] <= wd[4:0];
	end

	// =====================================================
	// Latches: only bus touches them, never calls or returns
	always_ff @(posedge clk) begin
		if (reset) begin
			latH_q <= 8'h00;
			latU_q <= 5'h00;
		end else if (busPclRd) begin
			latH_q <= pc_q[15:8];
			latU_q <= pc_q[20:16];
		end else begin
			if (wr & hitLatH)
				latH_q <= wd;
			if (wr & hitLatU)
				latU_q <= wd[4:0];
		end
	end

	// Configuration registers
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_q    <= CFG_RESET;
			memctl_q <= MEM_RESET;
			ctrl_q   <= CTRL_RESET;
		end else begin
			if (wr & hitCfg)
				cfg_q <= wd & CFG_MASK;
			if (wr & hitMem)
				memctl_q <= wd & MEM_MASK;
			if (wr & hitCtrl)
				ctrl_q <= {7'h00, wd[0]};
		end
	end

	// Bus answer one cycle after the request is taken
	always_ff @(posedge clk) begin
		if (reset) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= take;
			dat_q <= take ? {24'h000000, rdByte} : 32'h00000000;
		end
	end

	// =====================================================
	// Registered outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			fetchAddr_q  <= '0;
			fetchRoute_q <= '0;
			tblRoute_q   <= '0;
			busWide_q    <= 1'b0;
			waitCount_q  <= 2'h0;
			stackFault_q <= 1'b0;
		end else begin
			fetchAddr_q  <= warmReset ? 21'h000000 : pc_d;
			fetchRoute_q <= routeOf(mode, warmReset ? 21'h000000 : pc_d);
			tblRoute_q   <= routeOf(mode, tblAddr);
			busWide_q    <= cfg_q[CFG_BW];
			// waits off when bit 7 set
			waitCount_q  <= cfg_q[CFG_WAIT] ? 2'h0 : memctl_q[MEM_WAIT +: 2];
			// fault pulse; the system turns it into a device reset
			stackFault_q <= faultNow;
		end
	end

	// =====================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Bus pointer and low byte writes and device resets override the core, so core checks skip them
	wire quiet = ~warmReset & ~busSpWr & ~busPclWr;

	popEmpty_a: assert property (cmd.pop && sp_q == SP_EMPTY && quiet |=>
		pc_q == 21'h000000 && unf_q && sp_q == SP_EMPTY)
		else $error("empty pop did not return zero");
	pushStep_a: assert property (cmd.push && !cmd.pop && sp_q < 5'h1e && quiet |=>
		sp_q == $past(sp_q) + 5'h01 && tos == $past(pc_q) + PC_STEP)
		else $error("push did not step pointer or store return");
	popLoad_a: assert property (cmd.pop && sp_q != SP_EMPTY && quiet |=>
		pc_q == ($past(tos) & 21'h1ffffe) && sp_q == $past(sp_q) - 5'h01)
		else $error("pop loaded wrong address");
	fullSet_a: assert property (cmd.push && !cmd.pop && sp_q == 5'h1e && quiet |=>
		full_q && (stack_fault_reset_enable ? sp_q == SP_EMPTY : sp_q == SP_TOP))
		else $error("31st push mishandled");
	pclWrite_a: assert property (busPclWr && !warmReset |=>
		pc_q[20:8] == $past({latU_q, latH_q}))
		else $error("low byte write ignored latches");
	pclRead_a: assert property (busPclRd |=>
		latH_q == $past(pc_q[15:8]) && latU_q == $past(pc_q[20:16]))
		else $error("low byte read did not fill latches");
	jumpDirect_a: assert property (cmd.jump && !cmd.push && !cmd.pop && quiet |=>
		pc_q == ($past(cmd.target) & 21'h1ffffe) && $stable(latH_q))
		else $error("jump used latches");
	stepTwo_a: assert property (cmd.advance && !cmd.jump && !cmd.push && !cmd.pop && quiet
		|=> pc_q == $past(pc_q) + PC_STEP ##1 fetchAddr_q[0] == 1'b0)
		else $error("sequential step wrong");
	onchipBlock_a: assert property (mode == MM_ONCHIP && tblAddr > ONCHIP_LAST |=>
		tblRoute_q.blocked && !tblRoute_q.external)
		else $error("on-chip mode let high address through");
	extOnly_a: assert property (mode == MM_EXTONLY |=> tblRoute_q.external)
		else $error("external-only mode used flash");
	bootMap_a: assert property (mode == MM_BOOT |=>
		tblRoute_q.external == ($past(tblAddr) > BOOT_END))
		else $error("boot block split wrong");
	waitOff_a: assert property (cfg_q[CFG_WAIT] |=> waitCount_q == 2'h0)
		else $error("waits inserted while disabled");

	// =====================================================
	// Further stack, latch, routing and configuration checks
	latchKeep_a: assert property ((cmd.push || cmd.pop) && !wr && !busPclRd |=>
		$stable(latH_q) && $stable(latU_q))
		else $error("call or return touched latches");
	extendedMap_a: assert property (mode == MM_EXTENDED |=>
		tblRoute_q.external == ($past(tblAddr) > ONCHIP_LAST) && !tblRoute_q.blocked)
		else $error("extended mode split wrong");
	fullHold_a: assert property (cmd.push && !cmd.pop && sp_q == SP_TOP && !tosWr
		&& quiet |=> full_q && sp_q == SP_TOP && tos == $past(tos))
		else $error("push past full changed the stack");
	warmClear_a: assert property (warmReset |=>
		sp_q == SP_EMPTY && pc_q == 21'h000000 && fetchAddr_q == 21'h000000)
		else $error("device reset left pointer or counter");
	spWrite_a: assert property (busSpWr && !faultNow && !warmReset |=>
		sp_q == $past(wd[4:0]))
		else $error("pointer write lost");
	waitField_a: assert property (!cfg_q[CFG_WAIT] |=>
		waitCount_q == $past(memctl_q[MEM_WAIT +: 2]))
		else $error("wait count not taken from control field");
	fetchBlock_a: assert property (mode == MM_ONCHIP && pc_d > ONCHIP_LAST && quiet |=>
		fetchRoute_q.blocked && !fetchRoute_q.external)
		else $error("on-chip mode fetched outside");
	busWidth_a: assert property (1'b1 |=> busWide_q == $past(cfg_q[CFG_BW]))
		else $error("bus width does not follow config");
	unfClear_a: assert property (busSpWr && !wd[SPR_UNF] && !setUnf |=> !unf_q)
		else $error("underflow flag did not clear");
	unfSet_a: assert property (setUnf |=> unf_q)
		else $error("underflow flag not set");

	// Main scenarios
	cover property (cmd.push && sp_q == 5'h1e);
	cover property (cmd.pop && sp_q == SP_EMPTY);
	cover property (busPclRd ##[1:20] busPclWr);
	cover property (mode == MM_EXTENDED && fetchRoute_q.external);
	cover property (tosWr ##[1:20] cmd.pop);
endmodule
`default_nettype wire

/* verification/pcstk_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcstk_mem_model
	import pcstk_pkg::*;
(
	input  wire logic [20:0]             addr,  // Fetch address
	input  wire pcstk_pkg::pcstk_route_t route, // Fetch target
	output logic [15:0]                  instr  // Returned word
);
	// ==========================================
	// Memory behaviour
	// Top byte differs per memory so a wrong route shows in the data
	// blocked reads zero
	assign instr = route.blocked ? 16'h0000 : {(route.external ? 8'hee : 8'h1c), addr[7:0]};
endmodule
`default_nettype wire

/* verification/tb_pcstk_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pcstk_top;
	import pcstk_pkg::*;
	localparam logic [3:0] ADV = 4'h8;
	localparam logic [3:0] PSH = 4'h4;
	localparam logic [3:0] POPC = 4'h2;
	localparam logic [3:0] JMP = 4'h1;
	logic         clk, reset, warmReset, busWide, stackFault;
	pcstk_cmd_t   cmd;
	logic [20:0]  tblAddr, fetchAddr;
	pcstk_wbreq_t wbReq;
	pcstk_wbrsp_t wbRsp;
	pcstk_route_t fetchRoute, tblRoute;
	logic [1:0]   waitCount;
	logic [15:0]  instr;
	logic [31:0]  rd;
	int           failures, n_tests, cycles, faultCount;

	pcstk_top dut (.clk(clk), .reset(reset), .warmReset(warmReset), .cmd(cmd),
		.tblAddr(tblAddr), .wbReq(wbReq), .wbRsp(wbRsp), .fetchAddr_q(fetchAddr),
		.fetchRoute_q(fetchRoute), .tblRoute_q(tblRoute), .busWide_q(busWide),
		.waitCount_q(waitCount), .stackFault_q(stackFault));
	pcstk_mem_model mem (.addr(fetchAddr), .route(fetchRoute), .instr(instr));

	// ==========================================
	// Clock, timeout and fault pulse counting
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (stackFault === 1'b1) faultCount <= faultCount + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			results();
		end
	end

	// ==========================================
	// Shared tasks
	task results();
		if (failures == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled high
	task wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] sel);
		@(posedge clk);
		wbReq <= '{1'b1, 1'b1, we, sel, a, {24'h0, d}};
		do @(posedge clk); while (wbRsp.ack !== 1'b1);
		rd = wbRsp.dat;
		wbReq <= '0;
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 4'h1);
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00, 4'h0);
		chk(rd, {24'h0, exp});
	endtask
	// One core command for one cycle, then idle
	task step(input logic [3:0] k, input logic [20:0] t);
		@(posedge clk);
		cmd <= pcstk_cmd_t'({k, t});
		@(posedge clk);
		cmd <= '0;
		#1;
	endtask

	// ==========================================
	// Scenarios
	task testReset();
		rdc(ADR_CFG, 8'hc3);
		chk(busWide, 1);
		chk(waitCount, 0);
		rdc(ADR_SPTR, 8'h00);
		chk(fetchAddr, 0);
		rdc(ADR_CTRL, 8'h01);
	endtask
	task testModes();
		logic [20:0] al[5];
		logic [20:0] a;
		logic ext, blk;
		al = '{21'h0007fe, 21'h000800, 21'h003ffe, 21'h004000, 21'h1ffffe};
		for (int m = 0; m < 4; m++) begin
			wr(ADR_CFG, 8'hc0 | m[7:0]);
			rdc(ADR_CFG, 8'hc0 | m[7:0]);
			for (int i = 0; i < 5; i++) begin
				a = al[i];
				ext = (m == 2) || (m == 0 && a > ONCHIP_END) || (m == 1 && a > BOOT_END);
				blk = (m == 3) && (a > ONCHIP_END);
				@(posedge clk);
				tblAddr <= a;
				step(JMP, a);
				@(posedge clk);
				#1;
				chk(fetchAddr, a);
				chk(instr, blk ? 0 : {ext ? 8'hee : 8'h1c, a[7:0]});
				if (m == 3) begin
					chk(fetchRoute.blocked, blk);
					chk(tblRoute.blocked, blk);
				end else begin
					chk(fetchRoute, {ext, blk});
					chk(tblRoute, {ext, blk});
				end
			end
		end
		wr(ADR_CFG, 8'hc3);
	endtask
	task testConfigBits();
		wr(ADR_MEMCTL, 8'h20);
		rdc(ADR_MEMCTL, 8'h20);
		wr(ADR_CFG, 8'h03);
		@(posedge clk);
		#1;
		chk(waitCount, 2);
		chk(busWide, 0);
		wr(ADR_CFG, 8'h83);
		@(posedge clk);
		#1;
		chk(waitCount, 0);
		wr(ADR_CFG, 8'hc3);
	endtask
	task testCounter();
		step(JMP, 21'h000101);
		chk(fetchAddr, 21'h000100);
		step(ADV, 21'h0);
		chk(fetchAddr, 21'h000102);
	endtask
	task testLatches();
		wr(ADR_LATH, 8'h12);
		wr(ADR_LATU, 8'h05);
		wr(ADR_PCLOW, 8'h34);
		chk(fetchAddr, 21'h051234);
		step(JMP, 21'h0a5678);
		chk(fetchAddr, 21'h0a5678);
		rdc(ADR_PCLOW, 8'h78);
		rdc(ADR_LATH, 8'h56);
		rdc(ADR_LATU, 8'h0a);
	endtask
	task testStack();
		step(JMP, 21'h000100);
		step(PSH, 21'h000200);
		chk(fetchAddr, 21'h000200);
		rdc(ADR_SPTR, 8'h01);
		rdc(ADR_TOP_ENTRY_LOW, 8'h02);
		rdc(ADR_TOP_ENTRY_HIGH, 8'h01);
		step(PSH, 21'h150300);
		step(PSH, 21'h000400);
		rdc(ADR_TOP_ENTRY_UPPER, 8'h15);
		step(POPC, 21'h0);
		chk(fetchAddr, 21'h150302);
		rdc(ADR_SPTR, 8'h02);
		step(POPC, 21'h0);
		chk(fetchAddr, 21'h000202);
		step(POPC, 21'h0);
		chk(fetchAddr, 21'h000102);
		rdc(ADR_SPTR, 8'h00);
		rdc(ADR_LATH, 8'h56);
		rdc(ADR_LATU, 8'h0a);
	endtask
	task testTosWrite();
		// core stays idle while stack registers are edited
		wr(ADR_SPTR, 8'h05);
		wr(ADR_TOP_ENTRY_LOW, 8'h44);
		wr(ADR_TOP_ENTRY_HIGH, 8'h33);
		wr(ADR_TOP_ENTRY_UPPER, 8'h02);
		step(POPC, 21'h0);
		chk(fetchAddr, 21'h023344);
		rdc(ADR_SPTR, 8'h04);
		wr(ADR_SPTR, 8'h00);
	endtask
	task testUnderflow();
		wr(ADR_CTRL, 8'h00);
		step(JMP, 21'h000500);
		step(POPC, 21'h0);
		chk(fetchAddr, 0);
		rdc(ADR_SPTR, 8'h40);
		wr(ADR_SPTR, 8'h00);
		rdc(ADR_SPTR, 8'h00);
	endtask
	task testFull(input logic en);
		int f;
		wr(ADR_CTRL, {7'h0, en});
		wr(ADR_SPTR, 8'h00);
		f = faultCount;
		repeat (31) step(PSH, 21'h000600);
		rdc(ADR_SPTR, en ? 8'h80 : 8'h9f);
		chk(faultCount - f, {31'h0, en});
		if (!en) begin
			step(JMP, 21'h000700);
			step(PSH, 21'h000800);
			rdc(ADR_SPTR, 8'h9f);
			rdc(ADR_TOP_ENTRY_LOW, 8'h02);
			rdc(ADR_TOP_ENTRY_HIGH, 8'h06);
		end
		wr(ADR_SPTR, 8'h00);
	endtask
	task testRefuse();
		rdc(8'h30, 8'h00);
		wb(1'b1, ADR_LATH, 8'haa, 4'h0);
		rdc(ADR_LATH, 8'h56);
	endtask
	task testWarm();
		wr(ADR_SPTR, 8'h03);
		step(JMP, 21'h000900);
		@(posedge clk);
		warmReset <= 1'b1;
		@(posedge clk);
		warmReset <= 1'b0;
		#1;
		chk(fetchAddr, 0);
		rdc(ADR_SPTR, 8'h00);
		rdc(ADR_CFG, 8'hc3);
	endtask

	// ==========================================
	// Main sequence
	initial begin
		failures = 0;
		n_tests = 0;
		cycles = 0;
		faultCount = 0;
		reset = 1'b1;
		warmReset = 1'b0;
		cmd = '0;
		tblAddr = '0;
		wbReq = '0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		testReset();
		testModes();
		testConfigBits();
		testCounter();
		testLatches();
		testStack();
		testTosWrite();
		testUnderflow();
		testFull(1'b0);
		testFull(1'b1);
		testRefuse();
		testWarm();
		results();
	end
endmodule
`default_nettype wire
